// ==== design/vrx_pkg.sv ====
/*
  vrx_pkg: register offsets, reset values, field positions and carrier
  structs for the receiver timing, audio-pin and status register group.
  Assumes the serial control port engine outside presents decoded byte
  accesses (address, data, strobes) in the ref_clk domain.
*/
package vrx_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SYNC_INSERT_DE_GEN_CTRL = 8'h27;
  localparam logic [7:0] OFS_VERT_DELAY_HORIZ_DELAY_HI = 8'h28;
  localparam logic [7:0] OFS_HORIZ_DELAY_LO = 8'h29;
  localparam logic [7:0] OFS_LINE_WIDTH_HI = 8'h2a;
  localparam logic [7:0] OFS_LINE_WIDTH_LO = 8'h2b;
  localparam logic [7:0] OFS_SCREEN_HEIGHT_HI = 8'h2c;
  localparam logic [7:0] OFS_SCREEN_HEIGHT_LO = 8'h2d;
  localparam logic [7:0] OFS_AUDIO_PIN_OUTPUT_CFG = 8'h2e;
  localparam logic [7:0] OFS_LINK_STATUS_PRIMARY = 8'h2f;
  localparam logic [7:0] OFS_LINK_STATUS_SECONDARY = 8'h30;
  localparam logic [7:0] OFS_PSEUDO_SYNC_WIDTH_LIMITS = 8'h31;
  localparam logic [7:0] OFS_PSEUDO_SYNC_CFG_START = 8'h32;
  localparam logic [7:0] OFS_PSEUDO_SYNC_CFG_END = 8'h33;
  localparam logic [7:0] OFS_PSEUDO_SYNC_LIMIT_AUDIO_PLL = 8'h34;

  // ---------------------------------------------------------------
  // writable register slots: index, reset value, implemented bits
  // ---------------------------------------------------------------
  localparam int NUM_RW = 12;
  localparam logic [3:0] IDX_27 = 4'h0;
  localparam logic [3:0] IDX_28 = 4'h1;
  localparam logic [3:0] IDX_29 = 4'h2;
  localparam logic [3:0] IDX_2A = 4'h3;
  localparam logic [3:0] IDX_2B = 4'h4;
  localparam logic [3:0] IDX_2C = 4'h5;
  localparam logic [3:0] IDX_2D = 4'h6;
  localparam logic [3:0] IDX_2E = 4'h7;
  localparam logic [3:0] IDX_31 = 4'h8;
  localparam logic [3:0] IDX_32 = 4'h9;
  localparam logic [3:0] IDX_33 = 4'ha;
  localparam logic [3:0] IDX_34 = 4'hb;

  // sync_insert_de_gen_ctrl: bit 7 auto power-down reset 1, sync insert 0, force 0, offset 000
  localparam logic [7:0] RST_27 = 8'h80;
  // vert_delay_horiz_delay_hi: vertical delay 24 in 7:2, horizontal delay 0x104 upper bits 01
  localparam logic [7:0] RST_28 = 8'h61;
  localparam logic [7:0] RST_29 = 8'h04;
  localparam logic [7:0] RST_2A = 8'h05;
  localparam logic [7:0] RST_2B = 8'h00;
  localparam logic [7:0] RST_2C = 8'h02;
  localparam logic [7:0] RST_2D = 8'hd0;
  // audio_pin_output_cfg: word width 24, format 00, control-on-pins 0
  localparam logic [7:0] RST_2E = 8'h18;
  // pseudo_sync_width_limits: max 9, min 6
  localparam logic [7:0] RST_31 = 8'h96;
  // pseudo_sync_cfg_start: start line 13; pseudo_sync_cfg_end: end line 21; pseudo_sync_limit_audio_pll: limit code 10
  localparam logic [7:0] RST_32 = 8'h0d;
  localparam logic [7:0] RST_33 = 8'h15;
  localparam logic [7:0] RST_34 = 8'h80;

  localparam logic [7:0] MASK_NIBBLE = 8'h0f;
  localparam logic [7:0] MASK_FULL = 8'hff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_SYNC_INSERT = 4;
  localparam int BIT_GEN_FORCE = 3;
  localparam int BIT_CTRL_ON_PINS = 7;
  localparam int BIT_OVERSAMPLE = 7;
  localparam int BIT_STD_625 = 6;
  localparam int BIT_PROGRESSIVE = 7;
  localparam int BIT_OVERRIDE = 6;

  // pulse-limit code to pulse count
  localparam logic [2:0] LIMIT_CODE0 = 3'h6;
  localparam logic [2:0] LIMIT_CODE1 = 3'h4;
  localparam logic [2:0] LIMIT_CODE2 = 3'h5;
  localparam logic [2:0] LIMIT_CODE3 = 3'h7;

  typedef enum logic [1:0] {
    AFMT_I2S, AFMT_RIGHT, AFMT_LEFT, AFMT_RAW
  } vrx_afmt_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vrx_req_t;

  typedef struct packed {
    logic active_video_seen;
    logic clock_present;
    logic state_a;
    logic keys_loaded;
    logic [2:0] quality;
    logic decrypt_active;
    logic hsync_pol;
    logic vsync_pol;
    logic [3:0] pixel_rep;
  } vrx_status_t;

  typedef struct packed {
    logic sync_insert_en;
    logic internal_active_gen_force;
    logic [2:0] interlace_offset;
    logic [5:0] vsync_delay;
    logic [9:0] hsync_delay;
    logic [11:0] line_width;
    logic [11:0] screen_height;
    logic ctrl_on_audio_pins;
    vrx_afmt_t audio_format;
    logic [4:0] audio_word_width;
  } vrx_timing_t;

  typedef struct packed {
    logic std_625;
    logic progressive;
    logic [5:0] line_start;
    logic [5:0] line_end;
    logic [4:0] pulse_max;
    logic [4:0] pulse_min;
    logic [2:0] pulse_limit;
    logic stop;
  } vrx_detect_t;

endpackage : vrx_pkg

// ==== design/vrx_regs.sv ====
/*
  vrx_regs: timing, audio-pin, status and pseudo-sync detector register
  group of a video receiver, with the decoded settings it drives.
  Assumes the serial control port engine delivers one byte access per
  strobe on ref_clk, and that all status inputs are synchronous to it.
*/
// Operation
// - sync-word insertion enable, reset off
// - force internal active-video generator, reset off
// - second field offset in hsyncs, reset 0
// - vertical delay six bits, reset 24
// - ten-bit horizontal delay, reset 0x104
// - twelve-bit active line width, reset 0x500
// - twelve-bit active screen height, reset 0x2d0
// - control signals replace audio on pins
// - audio serial format select, reset I2S
// - right-justified sample width, reset 24
// - read active-video seen and clock present
// - read mute state and keys loaded
// - read link quality grade, larger better
// - decryption active bit, software polls it
// - read detected hsync and vsync polarity
// - read pixel repetition code n means n+1
// - pulse width max 9, min 6
// - oversample flag corrects detector clock counts
// - 625 or 525 rules; SD or progressive
// - detection window start 13, end 21
// - built-in or programmed detector settings
// - SD detector stops below pulse limit
module vrx_regs
  import vrx_pkg::*;
#(
  parameter logic [5:0] B525_LINE_START = 6'h0d,
  parameter logic [5:0] B525_LINE_END = 6'h15,
  parameter logic [5:0] B625_LINE_START = 6'h06,
  parameter logic [5:0] B625_LINE_END = 6'h0e,
  parameter logic [3:0] BUILTIN_PULSE_MAX = 4'h9,
  parameter logic [3:0] BUILTIN_PULSE_MIN = 4'h6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register access from the serial control port
  input wire vrx_req_t req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // link and content status
  input wire vrx_status_t status,
  // pulses counted by the detector over the last three lines
  input wire logic [3:0] pulses_last3,
  // decoded settings
  output vrx_timing_t timing,
  output vrx_detect_t detect
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_RW-1:0][7:0] rw;
    vrx_status_t st;
    logic [7:0] rd_data;
    logic rd_valid;
    vrx_timing_t timing;
    vrx_detect_t detect;
  } vrx_state_t;

  localparam logic [NUM_RW-1:0][7:0] RW_RESET = {
    RST_34, RST_33, RST_32, RST_31, RST_2E, RST_2D,
    RST_2C, RST_2B, RST_2A, RST_29, RST_28, RST_27
  };

  vrx_state_t state_reg;
  vrx_state_t state_next;

  // ---------------------------------------------------------------
  // address decode of the writable slots
  // ---------------------------------------------------------------
  function automatic logic [4:0] slot_of(input logic [7:0] a);
    logic [4:0] s;
    s = 5'h10;
    case (a)
      OFS_SYNC_INSERT_DE_GEN_CTRL: s = {1'b0, IDX_27};
      OFS_VERT_DELAY_HORIZ_DELAY_HI: s = {1'b0, IDX_28};
      OFS_HORIZ_DELAY_LO: s = {1'b0, IDX_29};
      OFS_LINE_WIDTH_HI: s = {1'b0, IDX_2A};
      OFS_LINE_WIDTH_LO: s = {1'b0, IDX_2B};
      OFS_SCREEN_HEIGHT_HI: s = {1'b0, IDX_2C};
      OFS_SCREEN_HEIGHT_LO: s = {1'b0, IDX_2D};
      OFS_AUDIO_PIN_OUTPUT_CFG: s = {1'b0, IDX_2E};
      OFS_PSEUDO_SYNC_WIDTH_LIMITS: s = {1'b0, IDX_31};
      OFS_PSEUDO_SYNC_CFG_START: s = {1'b0, IDX_32};
      OFS_PSEUDO_SYNC_CFG_END: s = {1'b0, IDX_33};
      OFS_PSEUDO_SYNC_LIMIT_AUDIO_PLL: s = {1'b0, IDX_34};
      default: s = 5'h10;
    endcase
    return s;
  endfunction : slot_of

  // upper nibbles of the two twelve-bit high bytes are not implemented
  function automatic logic [7:0] mask_of(input logic [3:0] i);
    logic [7:0] m;
    m = MASK_FULL;
    if (i == IDX_2A || i == IDX_2C) begin
      m = MASK_NIBBLE;
    end
    return m;
  endfunction : mask_of

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [4:0] slot;
  logic [7:0] r27, r28, r29, r2a, r2b, r2c, r2d, r2e;
  logic [7:0] r31, r32, r33, r34;
  logic [3:0] pmax, pmin;
  logic [7:0] status_primary;
  logic [7:0] status_secondary;

  always_comb begin
    state_next = state_reg;
    slot = slot_of(req.addr);

    // status is resampled every enabled cycle, so reads show it one enabled cycle old
    state_next.st = status;
    status_primary = {1'b0, state_reg.st.active_video_seen,
      state_reg.st.clock_present,
      state_reg.st.state_a, state_reg.st.keys_loaded,
      state_reg.st.quality};
    status_secondary = {1'b0, state_reg.st.decrypt_active,
      state_reg.st.hsync_pol, state_reg.st.vsync_pol,
      state_reg.st.pixel_rep};

    // writes to unmapped or status offsets fall through: no slot
    if (req.wr_en && !slot[4]) begin
      state_next.rw[slot[3:0]] = req.wdata & mask_of(slot[3:0]);
    end

    state_next.rd_valid = req.rd_en;
    state_next.rd_data = 8'h00;
    if (req.rd_en) begin
      if (!slot[4]) begin
        state_next.rd_data = state_reg.rw[slot[3:0]];
      end else if (req.addr == OFS_LINK_STATUS_PRIMARY) begin
        state_next.rd_data = status_primary;
      end else if (req.addr == OFS_LINK_STATUS_SECONDARY) begin
        state_next.rd_data = status_secondary;
      end
    end

    // decoded timing settings follow the stored bytes one cycle later
    r27 = state_reg.rw[IDX_27];
    r28 = state_reg.rw[IDX_28];
    r29 = state_reg.rw[IDX_29];
    r2a = state_reg.rw[IDX_2A];
    r2b = state_reg.rw[IDX_2B];
    r2c = state_reg.rw[IDX_2C];
    r2d = state_reg.rw[IDX_2D];
    r2e = state_reg.rw[IDX_2E];
    r31 = state_reg.rw[IDX_31];
    r32 = state_reg.rw[IDX_32];
    r33 = state_reg.rw[IDX_33];
    r34 = state_reg.rw[IDX_34];

    state_next.timing.sync_insert_en = r27[BIT_SYNC_INSERT];
    state_next.timing.internal_active_gen_force =
      r27[BIT_GEN_FORCE];
    state_next.timing.interlace_offset = r27[2:0];
    state_next.timing.vsync_delay = r28[7:2];
    state_next.timing.hsync_delay = {r28[1:0], r29};
    state_next.timing.line_width = {r2a[3:0], r2b};
    state_next.timing.screen_height = {r2c[3:0], r2d};
    state_next.timing.ctrl_on_audio_pins =
      r2e[BIT_CTRL_ON_PINS];
    state_next.timing.audio_format = vrx_afmt_t'(r2e[6:5]);
    state_next.timing.audio_word_width = r2e[4:0];

    // ---------------------------------------------------------------
    // pseudo-sync detector settings
    // ---------------------------------------------------------------
    state_next.detect.std_625 = r32[BIT_STD_625];
    state_next.detect.progressive = r33[BIT_PROGRESSIVE];
    if (r33[BIT_OVERRIDE]) begin
      state_next.detect.line_start = r32[5:0];
      state_next.detect.line_end = r33[5:0];
      pmax = r31[7:4];
      pmin = r31[3:0];
    end else begin
      pmax = BUILTIN_PULSE_MAX;
      pmin = BUILTIN_PULSE_MIN;
      if (r32[BIT_STD_625]) begin
        state_next.detect.line_start = B625_LINE_START;
        state_next.detect.line_end = B625_LINE_END;
      end else begin
        state_next.detect.line_start = B525_LINE_START;
        state_next.detect.line_end = B525_LINE_END;
      end
    end
    // widths are given at the base rate; oversampling doubles the count
    if (r32[BIT_OVERSAMPLE]) begin
      state_next.detect.pulse_max = {pmax, 1'b0};
      state_next.detect.pulse_min = {pmin, 1'b0};
    end else begin
      state_next.detect.pulse_max = {1'b0, pmax};
      state_next.detect.pulse_min = {1'b0, pmin};
    end

    case (r34[7:6])
      2'h0: state_next.detect.pulse_limit = LIMIT_CODE0;
      2'h1: state_next.detect.pulse_limit = LIMIT_CODE1;
      2'h2: state_next.detect.pulse_limit = LIMIT_CODE2;
      2'h3: state_next.detect.pulse_limit = LIMIT_CODE3;
      default: state_next.detect.pulse_limit = LIMIT_CODE2;
    endcase
    // progressive scan has no three-line pulse check
    state_next.detect.stop = !state_reg.detect.progressive &&
      (pulses_last3 < {1'b0, state_reg.detect.pulse_limit});
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.rw <= RW_RESET;
      state_reg.timing.vsync_delay <= RST_28[7:2];
      state_reg.timing.hsync_delay <= {RST_28[1:0], RST_29};
      state_reg.timing.line_width <= {RST_2A[3:0], RST_2B};
      state_reg.timing.screen_height <= {RST_2C[3:0], RST_2D};
      state_reg.timing.audio_word_width <= RST_2E[4:0];
      state_reg.detect.line_start <= B525_LINE_START;
      state_reg.detect.line_end <= B525_LINE_END;
      state_reg.detect.pulse_max <= {1'b0, BUILTIN_PULSE_MAX};
      state_reg.detect.pulse_min <= {1'b0, BUILTIN_PULSE_MIN};
      state_reg.detect.pulse_limit <= LIMIT_CODE2;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
  assign timing = state_reg.timing;
  assign detect = state_reg.detect;

endmodule : vrx_regs

// ==== sim/vrx_regs_properties.sv ====
/*
  vrx_regs_properties: port-level checks on the register group.
  Assumes one ref_clk domain, reset_n asynchronous and active low.
*/
module vrx_regs_properties
  import vrx_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register access
  input wire vrx_req_t req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // status and settings
  input wire vrx_status_t status,
  input wire logic [3:0] pulses_last3,
  input wire vrx_timing_t timing,
  input wire vrx_detect_t detect
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // status and stop lag reset release, so skip the first edges
  logic [1:0] age_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end

  // settings reach the outputs exactly two enabled edges after the write
  property p_ctl_bit(int b, logic o);
    clk_en && req.wr_en && req.addr == OFS_SYNC_INSERT_DE_GEN_CTRL
      |-> ##2 o == $past(req.wdata[b], 2);
  endproperty

  chk_read_answer: assert property (clk_en && req.rd_en |=> rd_valid)
    else $error("read got no answer");
  chk_idle_zero: assert property (!rd_valid |-> rd_data == 8'h00)
    else $error("read data not zero while idle");
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(rd_valid) && $stable(timing) && $stable(detect))
    else $error("state moved while frozen");
  chk_insert_follow: assert property (
    p_ctl_bit(BIT_SYNC_INSERT, timing.sync_insert_en))
    else $error("sync insert not taken");
  chk_force_follow: assert property (
    p_ctl_bit(BIT_GEN_FORCE, timing.internal_active_gen_force))
    else $error("generator force not taken");
  chk_status_primary: assert property (
    clk_en && req.rd_en && req.addr == OFS_LINK_STATUS_PRIMARY
    && age_reg == 2'h3 |=> rd_data == {1'b0, $past({status.active_video_seen,
    status.clock_present, status.state_a, status.keys_loaded,
    status.quality}, 2)})
    else $error("primary status read wrong");
  chk_status_second: assert property (
    clk_en && req.rd_en && req.addr == OFS_LINK_STATUS_SECONDARY
    && age_reg == 2'h3 |=> rd_data == {1'b0, $past({status.decrypt_active,
    status.hsync_pol, status.vsync_pol, status.pixel_rep}, 2)})
    else $error("secondary status read wrong");
  chk_timing_reset: assert property (
    $rose(reset_n) |-> timing.vsync_delay == 6'h18
    && timing.hsync_delay == 10'h104 && timing.line_width == 12'h500
    && timing.screen_height == 12'h2d0 && timing.audio_word_width == 5'h18)
    else $error("timing wrong after reset");
  chk_detect_reset: assert property (
    $rose(reset_n) |-> detect.line_start == 6'h0d && detect.line_end == 6'h15
    && detect.pulse_max == 5'h09 && detect.pulse_min == 5'h06
    && detect.pulse_limit == LIMIT_CODE2 && !detect.stop)
    else $error("detector wrong after reset");
  // stop lags one enabled edge behind the count and the stored settings
  chk_stop_rule: assert property (
    clk_en && age_reg == 2'h3 |=> detect.stop ==
    (!$past(detect.progressive)
    && $past(pulses_last3) < $past(detect.pulse_limit)))
    else $error("stop flag wrong");

  cover property (clk_en && req.rd_en
    && req.addr == OFS_LINK_STATUS_SECONDARY);
  cover property (detect.stop);
  cover property (req.wr_en && req.addr == OFS_LINK_STATUS_PRIMARY);
endmodule : vrx_regs_properties

bind vrx_regs vrx_regs_properties u_props (
  .ref_clk, .reset_n, .clk_en, .req, .rd_data, .rd_valid, .status,
  .pulses_last3, .timing, .detect
);

// ==== sim/vrx_host_model.sv ====
/*
  vrx_host_model: serial control port side issuing byte writes and reads.
  Assumes the register group answers a read one cycle after the strobe.
*/
module vrx_host_model
  import vrx_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register access
  output vrx_req_t req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  initial req = '0;

  // released lines carry inverted values so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    req <= {2'b10, a, v};
    @(posedge ref_clk);
    req <= {2'b00, ~a, ~v};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v,
    output logic ok);
    @(posedge ref_clk);
    req <= {2'b01, a, 8'h00};
    @(posedge ref_clk);
    req <= {2'b00, ~a, 8'hff};
    #1;
    ok = rd_valid;
    v = rd_data;
  endtask : rd
endmodule : vrx_host_model

// ==== sim/tb.sv ====
/*
  tb: directed test of the receiver register group via the host model.
  Assumes a 25 MHz ref_clk; status inputs held steady around reads.
*/
module tb
  import vrx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals, instances, helpers
  // ---------------------------------------------------------------
  logic ref_clk;
  logic reset_n;
  logic clk_en;
  vrx_req_t req;
  logic [7:0] rd_data;
  logic rd_valid;
  vrx_status_t status;
  logic [3:0] pulses_last3;
  vrx_timing_t timing;
  vrx_detect_t detect;
  int fail_count;
  int checks_done;
  logic [7:0] d;
  logic ok;
  logic [7:0] ofs [12] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d,
    8'h2e, 8'h31, 8'h32, 8'h33, 8'h34};
  logic [7:0] rst [12] = '{RST_27, RST_28, RST_29, RST_2A, RST_2B, RST_2C,
    RST_2D, RST_2E, RST_31, RST_32, RST_33, RST_34};
  logic [7:0] vals [12];
  logic [2:0] lim [4] = '{LIMIT_CODE0, LIMIT_CODE1, LIMIT_CODE2, LIMIT_CODE3};

  vrx_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .status(status),
    .pulses_last3(pulses_last3), .timing(timing), .detect(detect));
  vrx_host_model u_host (.ref_clk(ref_clk), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d, ok);
    chk("rd_valid", 32'h1, {31'h0, ok});
    chk("rd_data", {24'h0, e}, {24'h0, d});
  endtask : rchk

  // outputs follow a write two cycles later; wait one more for margin
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  function automatic logic [23:0] dsel();
    return {detect.std_625, detect.progressive, detect.line_start,
      detect.line_end, detect.pulse_max, detect.pulse_min};
  endfunction : dsel

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    pulses_last3 = 4'h0;
    status = 14'h36d9;
    fail_count = 0;
    checks_done = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) begin
      rchk(ofs[i], rst[i]);
    end
    foreach (ofs[i]) begin
      vals[i] = 8'h5a ^ 8'(i * 37);
      u_host.wr(ofs[i], vals[i]);
    end
    foreach (ofs[i]) begin
      rchk(ofs[i], (i == 3 || i == 5) ? vals[i] & MASK_NIBBLE : vals[i]);
    end
    settle();
    chk("ctl", vals[0][4:0], {timing.sync_insert_en,
      timing.internal_active_gen_force, timing.interlace_offset});
    chk("vdelay", vals[1][7:2], timing.vsync_delay);
    chk("hdelay", {vals[1][1:0], vals[2]}, timing.hsync_delay);
    chk("lwidth", {vals[3][3:0], vals[4]}, timing.line_width);
    chk("height", {vals[5][3:0], vals[6]}, timing.screen_height);
    for (int f = 0; f < 4; f++) begin
      u_host.wr(OFS_AUDIO_PIN_OUTPUT_CFG, {f[0], f[1:0], 5'h10 + 5'(f)});
      settle();
      chk("audio", {f[0], f[1:0], 5'h10 + 5'(f)},
        {timing.ctrl_on_audio_pins, timing.audio_format, timing.audio_word_width});
    end
    u_host.wr(OFS_LINK_STATUS_PRIMARY, 8'hff);
    u_host.wr(OFS_LINK_STATUS_SECONDARY, 8'h00);
    u_host.wr(8'h35, 8'hff);
    rchk(8'h26, 8'h00);
    rchk(8'h35, 8'h00);
    // status flips between polls, so each bit is seen at both levels
    repeat (2) begin
      rchk(OFS_LINK_STATUS_PRIMARY, {1'b0, status[13:7]});
      rchk(OFS_LINK_STATUS_SECONDARY, {1'b0, status[6:0]});
      @(posedge ref_clk);
      status <= ~status;
      repeat (2) @(posedge ref_clk);
    end
    u_host.wr(OFS_PSEUDO_SYNC_WIDTH_LIMITS, 8'h7a);
    u_host.wr(OFS_PSEUDO_SYNC_CFG_START, 8'h05);
    u_host.wr(OFS_PSEUDO_SYNC_CFG_END, 8'h07);
    settle();
    chk("builtin", {2'b00, 6'h0d, 6'h15, 5'h09, 5'h06}, dsel());
    u_host.wr(OFS_PSEUDO_SYNC_CFG_START, 8'h45);
    settle();
    chk("builtin625", {2'b10, 6'h06, 6'h0e, 5'h09, 5'h06}, dsel());
    u_host.wr(OFS_PSEUDO_SYNC_CFG_END, 8'hc7);
    settle();
    chk("programmed", {2'b11, 6'h05, 6'h07, 5'h07, 5'h0a}, dsel());
    u_host.wr(OFS_PSEUDO_SYNC_CFG_START, 8'hc5);
    settle();
    chk("oversample", {2'b11, 6'h05, 6'h07, 5'h0e, 5'h14}, dsel());
    u_host.wr(OFS_PSEUDO_SYNC_CFG_END, 8'h07);
    for (int c = 0; c < 4; c++) begin
      u_host.wr(OFS_PSEUDO_SYNC_LIMIT_AUDIO_PLL, {2'(c), 6'h00});
      @(posedge ref_clk);
      pulses_last3 <= {1'b0, lim[c]} - 4'h1;
      settle();
      chk("stop_below", {lim[c], 1'b1}, {detect.pulse_limit, detect.stop});
      @(posedge ref_clk);
      pulses_last3 <= {1'b0, lim[c]};
      settle();
      chk("stop_at", 32'h0, {31'h0, detect.stop});
    end
    u_host.wr(OFS_PSEUDO_SYNC_CFG_END, 8'h87);
    @(posedge ref_clk);
    pulses_last3 <= 4'h0;
    settle();
    chk("stop_prog", 32'h0, {31'h0, detect.stop});
    @(posedge ref_clk);
    clk_en <= 1'b0;
    u_host.rd(OFS_HORIZ_DELAY_LO, d, ok);
    chk("frozen", 32'h0, {31'h0, ok});
    @(posedge ref_clk);
    clk_en <= 1'b1;
    conclude();
  end
endmodule : tb
